//--- design/wwdt_map.svh
// register map, field positions, reset values and timing counts of the windowed watchdog
`ifndef WWDT_MAP_SVH
`define WWDT_MAP_SVH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define WWDT_ADDR_CTRL 8'h00
`define WWDT_ADDR_STAT 8'h01

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define WWDT_WIN_HI 7
`define WWDT_WIN_LO 4
`define WWDT_PER_HI 3
`define WWDT_PER_LO 0
`define WWDT_LOCK_BIT 7
`define WWDT_BUSY_BIT 0

// ----------------------------------------------------------------------------
// reset values and codes
// ----------------------------------------------------------------------------
`define WWDT_CTRL_RST 8'h00
`define WWDT_STAT_RST 8'h00
`define WWDT_CODE_OFF 4'h0
`define WWDT_CODE_MIN 4'h1
`define WWDT_CODE_MAX 4'hB

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define WWDT_SLOW_HZ 1024
`define WWDT_CNT_W 14
`define WWDT_BASE_CYC 14'h0008
`define WWDT_CNT_ZERO 14'h0000
`define WWDT_CNT_ONE 14'h0001
`define WWDT_SYNC_TICKS 2'h3
`define WWDT_SYNC_ZERO 2'h0
`define WWDT_SYNC_ONE 2'h1

`endif

//--- design/wwdt_pkg.sv
// types shared by the windowed watchdog modules
`include "wwdt_map.svh"

package wwdt_pkg;

  // ----------------------------------------------------------------------------
  // watchdog sequencer states, gray coded along off-open-closed-halt
  // ----------------------------------------------------------------------------
  typedef enum logic [1:0] {
    WWDT_OFF    = 2'h0,
    WWDT_OPEN   = 2'h1,
    WWDT_CLOSED = 2'h3,
    WWDT_HALT   = 2'h2
  } wwdt_state_e;

  // ----------------------------------------------------------------------------
  // state of the slow clock edge detector
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } wwdt_tick_s;

  // ----------------------------------------------------------------------------
  // state of the watchdog core
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] act;
    logic lock;
    logic sync_busy;
    logic [1:0] sync_cnt;
    logic clr_busy;
    logic [1:0] clr_cnt;
    wwdt_state_e fsm;
    logic [`WWDT_CNT_W-1:0] cnt;
    logic rst_req;
    logic [7:0] rdata;
    logic loaded;
    logic boot_seen;
  } wwdt_core_s;

endpackage

//--- design/wwdt_tick.sv
// slow oscillator synchroniser and rising edge detector
`timescale 1ns/1ps

module wwdt_tick (
  input wire logic clock,           // system clock
  input wire logic reset,           // async reset, active high
  input wire logic slow_osc_clock,  // slow watchdog oscillator
  output logic tick                 // one cycle per slow rising edge
);

  wwdt_pkg::wwdt_tick_s st_q;
  wwdt_pkg::wwdt_tick_s st_d;

  // two flop synchroniser, then a delay stage for the edge compare
  always_comb begin
    st_d = st_q;
    st_d.s1 = slow_osc_clock;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
  end

  // state register
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // edge seen only on synchronised copies
  assign tick = st_q.s2 & ~st_q.s3;

endmodule

//--- design/wwdt_core.sv
// windowed watchdog core with guarded configuration and clear synchroniser
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
`include "wwdt_map.svh"

module wwdt_core (
  input wire logic clock,               // system clock, 100 MHz
  input wire logic reset,               // async reset, active high
  input wire logic slow_osc_clock,      // slow watchdog oscillator
  input wire logic [7:0] addr,          // register address
  input wire logic [7:0] wr_data,       // register write data
  input wire logic wr_en,               // write strobe
  input wire logic rd_en,               // read strobe
  output logic [7:0] rd_data,           // read data, cycle after rd_en
  input wire logic guard_open,          // change_guard unlocked with io_key
  input wire logic [7:0] boot_config_fuse, // fuse value of control_a
  input wire logic boot_done,           // boot code finished, level
  input wire logic watchdog_clear_instr, // clear instruction, pulse
  input wire logic debug_halt,          // processor halted in debug
  output logic sys_reset_req            // system reset request, sticky
);

  // ----------------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------------

  // slow cycle count selected by a 4-bit code, reserved codes act as the longest
  function automatic logic [`WWDT_CNT_W-1:0] code_cycles(input logic [3:0] code);
    logic [3:0] c;
    c = code;
    if (c > `WWDT_CODE_MAX) begin
      c = `WWDT_CODE_MAX;
    end
    if (c == `WWDT_CODE_OFF) begin
      code_cycles = `WWDT_CNT_ZERO;
    end else begin
      code_cycles = `WWDT_BASE_CYC << (c - `WWDT_CODE_MIN);
    end
  endfunction

  wwdt_pkg::wwdt_core_s st_q;
  wwdt_pkg::wwdt_core_s st_d;
  logic tick;
  logic clr_go;
  logic sync_done;
  logic ctrl_wr_ok;
  logic stat_wr;
  logic [3:0] per_code;
  logic [3:0] win_code;
  logic [`WWDT_CNT_W-1:0] lim_open;
  logic [`WWDT_CNT_W-1:0] lim_closed;

  // ----------------------------------------------------------------------------
  // slow clock edges
  // ----------------------------------------------------------------------------

  // counter advances on slow clock edges; no sleep gating here
  wwdt_tick u_tick (
    .clock(clock),
    .reset(reset),
    .slow_osc_clock(slow_osc_clock),
    .tick(tick)
  );

  // ----------------------------------------------------------------------------
  // decode of active settings and events
  // ----------------------------------------------------------------------------

  // active fields as seen by the slow side
  assign per_code = st_q.act[`WWDT_PER_HI:`WWDT_PER_LO];
  assign win_code = st_q.act[`WWDT_WIN_HI:`WWDT_WIN_LO];
  assign lim_open = code_cycles(per_code);
  assign lim_closed = code_cycles(win_code);

  // end of clear and control synchronisation
  assign clr_go = st_q.clr_busy && tick && (st_q.clr_cnt == `WWDT_SYNC_TICKS - `WWDT_SYNC_ONE);
  assign sync_done = st_q.sync_busy && tick &&
    (st_q.sync_cnt == `WWDT_SYNC_TICKS - `WWDT_SYNC_ONE);

  // guarded, unfrozen control write; status write with key
  assign ctrl_wr_ok = wr_en && (addr == `WWDT_ADDR_CTRL) && guard_open && !st_q.lock &&
    st_q.loaded;
  assign stat_wr = wr_en && (addr == `WWDT_ADDR_STAT) && guard_open;

  // ----------------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------------

  // register file, synchronisers and window sequencer
  always_comb begin
    st_d = st_q;

    // read data stands for one cycle only
    st_d.rdata = 8'h00;
    if (rd_en && addr == `WWDT_ADDR_CTRL) begin
      st_d.rdata = st_q.ctrl;
    end else if (rd_en && addr == `WWDT_ADDR_STAT) begin
      st_d.rdata = `WWDT_STAT_RST;
      st_d.rdata[`WWDT_LOCK_BIT] = st_q.lock;
      st_d.rdata[`WWDT_BUSY_BIT] = st_q.sync_busy;
    end

    // first cycle after reset takes the fuse value
    if (!st_q.loaded) begin
      st_d.ctrl = boot_config_fuse;
      st_d.act = boot_config_fuse;
      st_d.loaded = 1'b1;
    end

    // control transfer into the slow side
    if (st_q.sync_busy && tick) begin
      st_d.sync_cnt = st_q.sync_cnt + `WWDT_SYNC_ONE;
    end
    if (sync_done) begin
      st_d.act = st_q.ctrl;
      st_d.sync_busy = 1'b0;
    end

    // accepted write restarts transfer; unguarded or frozen writes drop
    if (ctrl_wr_ok) begin
      st_d.ctrl = wr_data;
      st_d.sync_busy = 1'b1;
      st_d.sync_cnt = `WWDT_SYNC_ZERO;
    end

    // freeze bit: set by one, cleared only while halted
    if (stat_wr && wr_data[`WWDT_LOCK_BIT]) begin
      st_d.lock = 1'b1;
    end else if (stat_wr && debug_halt) begin
      st_d.lock = 1'b0;
    end

    // once boot code is done, a running watchdog freezes its setup; set beats a debug clear
    if (st_q.loaded && !st_q.boot_seen && boot_done) begin
      st_d.boot_seen = 1'b1;
      if (st_q.ctrl[`WWDT_PER_HI:`WWDT_PER_LO] != `WWDT_CODE_OFF) begin
        st_d.lock = 1'b1;
      end
    end

    // clear synchroniser; clears during it are dropped
    if (st_q.clr_busy && tick) begin
      st_d.clr_cnt = st_q.clr_cnt + `WWDT_SYNC_ONE;
    end
    if (clr_go) begin
      st_d.clr_busy = 1'b0;
    end
    if (watchdog_clear_instr && !st_q.clr_busy && !debug_halt) begin
      st_d.clr_busy = 1'b1;
      st_d.clr_cnt = `WWDT_SYNC_ZERO;
    end

    // window sequencer
    case (st_q.fsm)
      wwdt_pkg::WWDT_OFF: begin
        st_d.cnt = `WWDT_CNT_ZERO;
        if (per_code != `WWDT_CODE_OFF) begin
          st_d.fsm = wwdt_pkg::WWDT_OPEN;
        end
      end
      wwdt_pkg::WWDT_OPEN: begin
        if (per_code == `WWDT_CODE_OFF) begin
          st_d.fsm = wwdt_pkg::WWDT_OFF;
          st_d.cnt = `WWDT_CNT_ZERO;
        end else if (clr_go) begin
          st_d.cnt = `WWDT_CNT_ZERO;
          if (win_code != `WWDT_CODE_OFF) begin
            st_d.fsm = wwdt_pkg::WWDT_CLOSED;
          end
        end else if (tick) begin
          if (st_q.cnt == lim_open - `WWDT_CNT_ONE) begin
            st_d.rst_req = 1'b1;
          end else begin
            st_d.cnt = st_q.cnt + `WWDT_CNT_ONE;
          end
        end
      end
      wwdt_pkg::WWDT_CLOSED: begin
        if (per_code == `WWDT_CODE_OFF) begin
          st_d.fsm = wwdt_pkg::WWDT_OFF;
          st_d.cnt = `WWDT_CNT_ZERO;
        end else if (clr_go) begin
          st_d.rst_req = 1'b1;
        end else if (win_code == `WWDT_CODE_OFF) begin
          st_d.fsm = wwdt_pkg::WWDT_OPEN;
          st_d.cnt = `WWDT_CNT_ZERO;
        end else if (tick) begin
          if (st_q.cnt == lim_closed - `WWDT_CNT_ONE) begin
            st_d.fsm = wwdt_pkg::WWDT_OPEN;
            st_d.cnt = `WWDT_CNT_ZERO;
          end else begin
            st_d.cnt = st_q.cnt + `WWDT_CNT_ONE;
          end
        end
      end
      wwdt_pkg::WWDT_HALT: begin
        st_d.cnt = `WWDT_CNT_ZERO;
        if (!debug_halt) begin
          // resume runs an open period; closed waits for a clear
          st_d.fsm = (per_code != `WWDT_CODE_OFF) ? wwdt_pkg::WWDT_OPEN :
            wwdt_pkg::WWDT_OFF;
        end
      end
      default: begin
        st_d.fsm = wwdt_pkg::WWDT_OFF;
        st_d.cnt = `WWDT_CNT_ZERO;
      end
    endcase

    // window mode newly enabled: wait for the first clear in an open period
    if (sync_done && win_code == `WWDT_CODE_OFF &&
        st_q.ctrl[`WWDT_WIN_HI:`WWDT_WIN_LO] != `WWDT_CODE_OFF &&
        st_d.fsm != wwdt_pkg::WWDT_OFF && !debug_halt) begin
      st_d.fsm = wwdt_pkg::WWDT_OPEN;
      st_d.cnt = `WWDT_CNT_ZERO;
    end

    // debug halt stops the watchdog and clears its counter
    if (debug_halt) begin
      st_d.fsm = wwdt_pkg::WWDT_HALT;
      st_d.cnt = `WWDT_CNT_ZERO;
      st_d.clr_busy = 1'b0;
    end
  end

  // ----------------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------------

  // all state is constant under reset; fuse value loads after release
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from flops
  assign rd_data = st_q.rdata;
  assign sys_reset_req = st_q.rst_req;

  // ----------------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------------

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);

  // unguarded control write leaves control_a alone
  a_ctrl_unguarded: assert property (
    (wr_en && addr == `WWDT_ADDR_CTRL && !guard_open && st_q.loaded) |=>
      (st_q.ctrl == $past(st_q.ctrl)))
    else $error("unguarded control write changed control_a");

  // frozen configuration is never changed
  a_ctrl_frozen: assert property (
    (st_q.lock && st_q.loaded) |=> (st_q.ctrl == $past(st_q.ctrl)))
    else $error("control_a changed while frozen");

  // accepted write raises sync_pending and it reads back on bit 0
  a_busy_raise: assert property (
    (ctrl_wr_ok ##2 (rd_en && addr == `WWDT_ADDR_STAT)) |=>
      rd_data[`WWDT_BUSY_BIT])
    else $error("sync_pending not shown after control write");

  // transfer completes: busy drops and active value follows control_a
  a_busy_clear: assert property (
    (sync_done && !ctrl_wr_ok) |=> (!st_q.sync_busy && st_q.act == $past(st_q.ctrl)))
    else $error("control transfer did not complete");

  // disabled watchdog falls to off
  a_enable_off: assert property (
    ((st_q.fsm == wwdt_pkg::WWDT_OPEN || st_q.fsm == wwdt_pkg::WWDT_CLOSED) &&
      per_code == `WWDT_CODE_OFF && !debug_halt) |=> (st_q.fsm == wwdt_pkg::WWDT_OFF))
    else $error("watchdog still running with zero period");

  // early clear in closed period requests reset
  a_closed_clear: assert property (
    (st_q.fsm == wwdt_pkg::WWDT_CLOSED && clr_go && per_code != `WWDT_CODE_OFF &&
      !debug_halt) |=> sys_reset_req)
    else $error("early clear did not reset");

  // expiry of the open period requests reset
  a_open_expire: assert property (
    (st_q.fsm == wwdt_pkg::WWDT_OPEN && tick && !clr_go && !debug_halt &&
      per_code != `WWDT_CODE_OFF && st_q.cnt == lim_open - `WWDT_CNT_ONE &&
      !(sync_done && st_q.ctrl != st_q.act)) |=> sys_reset_req)
    else $error("open period expired without reset");

  // clear in normal mode restarts counting
  a_clear_restart: assert property (
    (st_q.fsm == wwdt_pkg::WWDT_OPEN && clr_go && !debug_halt && !sync_done &&
      per_code != `WWDT_CODE_OFF) |=> (st_q.cnt == `WWDT_CNT_ZERO))
    else $error("clear did not restart the counter");

  // clear during synchronisation is ignored
  a_clear_ignored: assert property (
    (st_q.clr_busy && watchdog_clear_instr && !tick && !debug_halt) |=>
      (st_q.clr_busy && st_q.clr_cnt == $past(st_q.clr_cnt)))
    else $error("second clear disturbed synchronisation");

  // debug halt holds the counter at zero
  a_halt_reset: assert property (
    debug_halt |=> (st_q.fsm == wwdt_pkg::WWDT_HALT && st_q.cnt == `WWDT_CNT_ZERO))
    else $error("debug halt did not stop the watchdog");

  // freeze bit survives a zero write outside debug
  a_lock_sticky: assert property (
    (st_q.lock && !debug_halt) |=> st_q.lock)
    else $error("config_freeze cleared outside debug");

endmodule

//--- verification/wwdt_cpu_model.sv
// processor-side model: register accesses, key window and clear instructions
`timescale 1ns/1ps

module wwdt_cpu_model (
  input wire logic clock,            // system clock
  output logic [7:0] addr,           // register address
  output logic [7:0] wr_data,        // register write data
  output logic wr_en,                // write strobe
  output logic rd_en,                // read strobe
  input wire logic [7:0] rd_data,    // read data, cycle after rd_en
  output logic guard_open,           // key window open
  output logic watchdog_clear_instr  // clear instruction pulse
);
  // ---------------------------------------------------------------------------
  // idle levels at time zero
  // ---------------------------------------------------------------------------
  initial begin
    addr = 8'hA5;
    wr_data = 8'h5A;
    wr_en = 1'b0;
    rd_en = 1'b0;
    guard_open = 1'b0;
    watchdog_clear_instr = 1'b0;
  end

  // key first, then the guarded write in the next instruction slot
  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d, input logic key);
    @(posedge clock);
    guard_open <= key;
    @(posedge clock);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
    guard_open <= 1'b0;
    addr <= ~a;
    wr_data <= ~d;
  endtask

  // one-cycle read strobe, data taken in the following cycle
  task automatic bus_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    addr <= ~a;
    #1;
    d = rd_data;
  endtask

  // service the watchdog with one clear instruction
  task automatic clear_pulse();
    @(posedge clock);
    watchdog_clear_instr <= 1'b1;
    @(posedge clock);
    watchdog_clear_instr <= 1'b0;
  endtask
endmodule

//--- verification/test_windowed_watchdog_timer.sv
// self-checking testbench of the windowed watchdog core
`timescale 1ns/1ps
`include "wwdt_map.svh"

module test_windowed_watchdog_timer;
  logic clock, reset, slow_osc_clock, boot_done, debug_halt, sys_reset_req;
  logic [7:0] addr, wr_data, rd_data, boot_config_fuse, v;
  logic wr_en, rd_en, guard_open, watchdog_clear_instr;
  int n_mismatch, n_compared, seed, m_ctrl, m_lock, lim, n;

  // ---------------------------------------------------------------------------
  // clocks: 100 MHz system, fast stand-in for the slow oscillator
  // ---------------------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    slow_osc_clock = 1'b0;
    // fractional half period keeps slow edges off the system clock edges, except every 50th toggle
    forever #47.3 slow_osc_clock = ~slow_osc_clock;
  end

  wwdt_core dut (.clock(clock), .reset(reset), .slow_osc_clock(slow_osc_clock),
    .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .guard_open(guard_open), .boot_config_fuse(boot_config_fuse), .boot_done(boot_done),
    .watchdog_clear_instr(watchdog_clear_instr), .debug_halt(debug_halt),
    .sys_reset_req(sys_reset_req));

  wwdt_cpu_model cpu (.clock(clock), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .guard_open(guard_open),
    .watchdog_clear_instr(watchdog_clear_instr));

  // ---------------------------------------------------------------------------
  // reporting
  // ---------------------------------------------------------------------------
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // reset, bus wrappers with the register model, bounded waits
  // ---------------------------------------------------------------------------
  task automatic do_reset(input logic [7:0] f);
    @(posedge clock);
    reset <= 1'b1;
    boot_config_fuse <= f;
    boot_done <= 1'b0;
    debug_halt <= 1'b0;
    repeat (16) @(posedge clock);
    reset <= 1'b0;
    repeat (3) @(posedge clock);
    boot_done <= 1'b1;
    repeat (2) @(posedge clock);
    m_ctrl = f;
    m_lock = (f[3:0] != 4'h0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic key);
    cpu.bus_wr(a, d, key);
    if (key && a == `WWDT_ADDR_CTRL && m_lock == 0) m_ctrl = d;
    if (key && a == `WWDT_ADDR_STAT && d[7]) m_lock = 1;
    else if (key && a == `WWDT_ADDR_STAT && debug_halt) m_lock = 0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string name);
    cpu.bus_rd(a, v);
    check(name, {8'h00, v}, {8'h00, exp});
  endtask

  // poll until the control transfer is over; no control write meanwhile
  task automatic wait_sync();
    v = 8'h01;
    for (int i = 0; i < 200 && v[0] !== 1'b0; i++) cpu.bus_rd(`WWDT_ADDR_STAT, v);
    if (v[0] !== 1'b0) begin
      n_mismatch++;
      finish_test();
    end
  endtask

  // slow edges seen until the reset request, bounded
  task automatic to_reset(output int k);
    k = 0;
    while (sys_reset_req !== 1'b1 && k < 400) begin
      @(posedge slow_osc_clock);
      #60;
      k++;
    end
  endtask

  task automatic ticks(input int k);
    repeat (k) @(posedge slow_osc_clock);
  endtask

  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    seed = 84504;
    n_mismatch = 0;
    n_compared = 0;
    reset = 1'b1;
    boot_config_fuse = 8'h00;
    boot_done = 1'b0;
    debug_halt = 1'b0;
    // boot without fuse, unguarded writes refused
    do_reset(8'h00);
    rd_chk(`WWDT_ADDR_CTRL, m_ctrl, "ctrl_boot");
    rd_chk(`WWDT_ADDR_STAT, 8'h00, "stat_boot");
    v = $random(seed);
    wr(`WWDT_ADDR_CTRL, v, 1'b0);
    rd_chk(`WWDT_ADDR_CTRL, m_ctrl, "ctrl_nokey");
    wr(`WWDT_ADDR_STAT, 8'h80, 1'b0);
    rd_chk(`WWDT_ADDR_STAT, 8'h00, "stat_nokey");
    ticks(20);
    check("off_no_rst", {15'h0, sys_reset_req}, 16'h0000);
    $display("test boot_guard done");
    // normal mode timeout for period codes 1 to 6
    for (int c = 1; c <= 6; c++) begin
      do_reset(8'h00);
      v = $random(seed);
      wr(`WWDT_ADDR_CTRL, {4'h0, c[3:0]}, 1'b1);
      rd_chk(`WWDT_ADDR_STAT, 8'h01, "sync_set");
      rd_chk(`WWDT_ADDR_CTRL, m_ctrl, "ctrl_val");
      wait_sync();
      to_reset(n);
      lim = 8 << (c - 1);
      check("normal_to", {15'h0, n >= lim - 1 && n <= lim + 1}, 16'h0001);
    end
    $display("test period_codes done");
    // clears keep the watchdog alive
    do_reset(8'h00);
    wr(`WWDT_ADDR_CTRL, 8'h02, 1'b1);
    wait_sync();
    repeat (5) begin
      ticks(10);
      cpu.clear_pulse();
    end
    #1;
    check("kept_alive", {15'h0, sys_reset_req}, 16'h0000);
    to_reset(n);
    // clear lands on the third slow edge, then a full 16-cycle period runs
    check("late_to", {15'h0, n >= 17 && n <= 19}, 16'h0001);
    $display("test keep_alive done");
    // window mode: ignored second clear, open clear, early clear
    do_reset(8'h00);
    wr(`WWDT_ADDR_CTRL, 8'h11, 1'b1);
    wait_sync();
    cpu.clear_pulse();
    cpu.clear_pulse();
    ticks(13);
    check("win_first", {15'h0, sys_reset_req}, 16'h0000);
    cpu.clear_pulse();
    ticks(4);
    check("win_open", {15'h0, sys_reset_req}, 16'h0000);
    cpu.clear_pulse();
    ticks(6);
    check("win_early", {15'h0, sys_reset_req}, 16'h0001);
    do_reset(8'h00);
    wr(`WWDT_ADDR_CTRL, 8'h11, 1'b1);
    wait_sync();
    cpu.clear_pulse();
    to_reset(n);
    check("win_sum", {15'h0, n >= 17 && n <= 21}, 16'h0001);
    $display("test window done");
    // fuse boot, freeze, debug halt and resume
    do_reset(8'h31);
    rd_chk(`WWDT_ADDR_CTRL, m_ctrl, "ctrl_fuse");
    rd_chk(`WWDT_ADDR_STAT, 8'h80, "freeze_auto");
    wr(`WWDT_ADDR_CTRL, 8'h00, 1'b1);
    rd_chk(`WWDT_ADDR_CTRL, m_ctrl, "ctrl_frozen");
    wr(`WWDT_ADDR_STAT, 8'h00, 1'b1);
    rd_chk(`WWDT_ADDR_STAT, {m_lock[0], 7'h00}, "freeze_kept");
    @(posedge clock);
    debug_halt <= 1'b1;
    wr(`WWDT_ADDR_STAT, 8'h00, 1'b1);
    rd_chk(`WWDT_ADDR_STAT, {m_lock[0], 7'h00}, "freeze_dbg");
    ticks(40);
    check("halt_no_rst", {15'h0, sys_reset_req}, 16'h0000);
    @(posedge clock);
    debug_halt <= 1'b0;
    to_reset(n);
    check("resume_to", {15'h0, n >= 7 && n <= 9}, 16'h0001);
    $display("test debug done");
    finish_test();
  end

  // cut a hang short
  initial begin
    repeat (100000) @(posedge clock);
    n_mismatch++;
    finish_test();
  end
endmodule
